// file: rtl/ftc_cfg.svh
`ifndef FTC_CFG_SVH
`define FTC_CFG_SVH
// Register offsets
`define FTC_OFF_LIMIT    8'h7a
`define FTC_OFF_PULSES   8'h7b
`define FTC_OFF_CFG5     8'h7c
// Reset values
`define FTC_RST_LIMIT    8'h00
`define FTC_RST_PULSES   8'h55
`define FTC_RST_CFG5     8'h00
// Configuration word bit positions
`define FTC_BIT_TWOS     0
`define FTC_BIT_BAND     1
`define FTC_BIT_GPIO_DIRECTION    2
`define FTC_BIT_GPIO_POLARITY    3
// Pin function codes
`define FTC_PIN_TACH     2'h0
`define FTC_PIN_OVT      2'h1
`define FTC_PIN_ALERT    2'h2
`define FTC_PIN_GPIO     2'h3
// Timing: one step in microseconds, clock period in nanoseconds
`define FTC_STEP_US      22760
`define FTC_CLK_NS       100
`define FTC_STEP_CYC     ((`FTC_STEP_US * 1000) / `FTC_CLK_NS)
// Steps of assertion before the timer reads non-zero (45.52 ms)
`define FTC_MIN_STEPS    8'h02
`define FTC_TEMP_OFFSET  8'h40
`endif

// file: rtl/ftc_pkg.sv
package ftc_pkg;
	// Decoded configuration word
	typedef struct packed {
		logic [3:0] spare;
		logic       gpio_polarity;
		logic       gpio_direction;
		logic       pwm_band_sel;
		logic       twos_compl;
	} ftc_cfg5_s;
	// Per-fan pulse-count fields
	typedef struct packed {
		logic [1:0] pulse_count_sel_d;
		logic [1:0] pulse_count_sel_c;
		logic [1:0] pulse_count_sel_b;
		logic [1:0] pulse_count_sel_a;
	} ftc_pulses_s;
	// Register access request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ftc_req_s;
	typedef enum logic [1:0] {
		FTC_IDLE, FTC_TIMING, FTC_TRIPPED
	} ftc_tstate_e;
endpackage : ftc_pkg

// file: rtl/ftc_regs.sv
`timescale 1ns/100ps
`include "ftc_cfg.svh"
// How it works
// - Eight-bit read/write assertion limit register
// - Each limit step weighs 22.76 ms
// - Over-limit assertion sets interrupt flag bit
// - Zero limit flags immediately on assertion
// - Two-bit code selects one to four pulses
// - Four fan fields packed, reset 0x55
// - Bit 0 selects twos complement or offset
// - Stored temperatures reinterpreted in new format
// - Bit 1 selects high or low PWM band
// - Bit 2 sets GPIO direction when active
// - Bit 3 sets GPIO output polarity
// - Lock makes configuration word read-only
// - Timer reads zero below 45.52 ms
// - Two-bit selector picks multi-function pin role
module ftc_regs
	import ftc_pkg::*;
#(
	parameter int STEP_CYC = `FTC_STEP_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Register port, same clock domain
	input  wire ftc_req_s    req,
	output logic [7:0]       rdata,
	// Lock from configuration register 1, pin role selector
	input  wire logic        cfg_lock,
	input  wire logic [1:0]  pin_func_sel,
	// Overtemperature pin, active low, asynchronous
	input  wire logic        overtemp_signal_n,
	// Flag status and clear from interrupt status path
	input  wire logic        int_flag_clr,
	output logic             pulse_count_sel_d_or_overtemp_int_flag,
	output logic [7:0]       assert_time_count,
	// Decoded configuration towards other blocks
	output ftc_pulses_s      pulse_sel,
	output logic [2:0]       pulse_count_a,
	output logic [2:0]       pulse_count_b,
	output logic [2:0]       pulse_count_c,
	output logic [2:0]       pulse_count_d,
	output logic             twos_compl,
	output logic             pwm_band_sel,
	output logic             fourth_speed_input_en,
	output logic             overtemp_pin_en,
	// Temperature conversion of a stored raw value
	input  wire logic [7:0]  temp_raw,
	output logic [7:0]       temp_signed,
	// GPIO pin, five signals
	input  wire logic        gpio_in,
	input  wire logic        gpio_level,
	output logic             gpio_out,
	output logic             gpio_oe_n,
	output logic             gpio_in_active
);

	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------
	logic [7:0]     assert_time_limit_reg;
	ftc_pulses_s    pulses_reg;
	ftc_cfg5_s      cfg5_reg;
	logic [7:0]     rdata_reg;
	logic           ovt_s1_reg;
	logic           ovt_s2_reg;
	logic           gpio_s1_reg;
	logic           gpio_s2_reg;
	logic [31:0]    step_cnt_reg;
	logic [7:0]     steps_reg;
	logic           flag_reg;
	ftc_tstate_e    tstate_reg;
	logic           ovt_active;
	logic           gpio_mode;

	// Code n selects n+1 pulses
	function automatic logic [2:0] pulses_of(input logic [1:0] code);
		pulses_of = {1'b0, code} + 3'h1;
	endfunction : pulses_of

	//------------------------------------------------------------
	// Register writes
	//------------------------------------------------------------
	// Limit register
	always_ff @(posedge core_clk) begin
		if (srst)
			assert_time_limit_reg <= `FTC_RST_LIMIT;
		else if (req.wr && req.addr == `FTC_OFF_LIMIT)
			assert_time_limit_reg <= req.wdata;
	end

	// Pulse-count register
	always_ff @(posedge core_clk) begin
		if (srst)
			pulses_reg <= `FTC_RST_PULSES;
		else if (req.wr && req.addr == `FTC_OFF_PULSES)
			pulses_reg <= req.wdata;
	end

	// Config word; lock makes writes vanish silently
	always_ff @(posedge core_clk) begin
		if (srst)
			cfg5_reg <= `FTC_RST_CFG5;
		else if (req.wr && req.addr == `FTC_OFF_CFG5 && !cfg_lock)
			cfg5_reg <= req.wdata;
	end

	// Read data registered; unmapped reads give zero
	always_ff @(posedge core_clk) begin
		if (srst)
			rdata_reg <= 8'h00;
		else if (req.rd) begin
			case (req.addr)
				`FTC_OFF_LIMIT:  rdata_reg <= assert_time_limit_reg;
				`FTC_OFF_PULSES: rdata_reg <= pulses_reg;
				`FTC_OFF_CFG5:   rdata_reg <= cfg5_reg;
				default:         rdata_reg <= 8'h00;
			endcase
		end
	end
	assign rdata = rdata_reg;

	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	// Two flops before any logic reads the pins
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ovt_s1_reg  <= 1'b0;
			ovt_s2_reg  <= 1'b0;
			gpio_s1_reg <= 1'b0;
			gpio_s2_reg <= 1'b0;
		end else begin
			ovt_s1_reg  <= ~overtemp_signal_n;
			ovt_s2_reg  <= ovt_s1_reg;
			gpio_s1_reg <= gpio_in;
			gpio_s2_reg <= gpio_s1_reg;
		end
	end

	// Timer only watches the pin when it is in the overtemp role
	assign ovt_active = ovt_s2_reg && (pin_func_sel == `FTC_PIN_OVT);

	//------------------------------------------------------------
	// Assertion timer
	//------------------------------------------------------------
	// Step prescaler; restarts with each new assertion
	always_ff @(posedge core_clk) begin
		if (srst || !ovt_active)
			step_cnt_reg <= 32'h0;
		else if (step_cnt_reg == 32'(STEP_CYC - 1))
			step_cnt_reg <= 32'h0;
		else
			step_cnt_reg <= step_cnt_reg + 32'h1;
	end

	// Whole steps, saturating so long assertions do not wrap
	always_ff @(posedge core_clk) begin
		if (srst || !ovt_active)
			steps_reg <= 8'h00;
		else if (step_cnt_reg == 32'(STEP_CYC - 1) && steps_reg != 8'hff)
			steps_reg <= steps_reg + 8'h01;
	end

	// Zero until two steps have elapsed
	assign assert_time_count =
		(steps_reg >= `FTC_MIN_STEPS) ? steps_reg : 8'h00;

	// Compare state: one trip per assertion
	always_ff @(posedge core_clk) begin
		if (srst)
			tstate_reg <= FTC_IDLE;
		else begin
			case (tstate_reg)
				FTC_IDLE:
					if (ovt_active)
						tstate_reg <= FTC_TIMING;
				FTC_TIMING:
					if (!ovt_active)
						tstate_reg <= FTC_IDLE;
					else if (steps_reg > assert_time_limit_reg)
						tstate_reg <= FTC_TRIPPED;
				FTC_TRIPPED:
					if (!ovt_active)
						tstate_reg <= FTC_IDLE;
				default:
					tstate_reg <= FTC_IDLE;
			endcase
		end
	end

	// Sticky flag; set wins over a same-cycle clear
	always_ff @(posedge core_clk) begin
		if (srst)
			flag_reg <= 1'b0;
		else if (ovt_active && assert_time_limit_reg == 8'h00)
			flag_reg <= 1'b1;
		else if (tstate_reg == FTC_TIMING && ovt_active
			&& steps_reg > assert_time_limit_reg)
			flag_reg <= 1'b1;
		else if (int_flag_clr)
			flag_reg <= 1'b0;
	end
	assign pulse_count_sel_d_or_overtemp_int_flag = flag_reg;

	//------------------------------------------------------------
	// Decoded outputs
	//------------------------------------------------------------
	assign pulse_sel     = pulses_reg;
	assign pulse_count_a = pulses_of(pulses_reg.pulse_count_sel_a);
	assign pulse_count_b = pulses_of(pulses_reg.pulse_count_sel_b);
	assign pulse_count_c = pulses_of(pulses_reg.pulse_count_sel_c);
	assign pulse_count_d = pulses_of(pulses_reg.pulse_count_sel_d);
	assign twos_compl    = cfg5_reg.twos_compl;
	assign pwm_band_sel  = cfg5_reg.pwm_band_sel;
	assign fourth_speed_input_en = (pin_func_sel == `FTC_PIN_TACH);
	assign overtemp_pin_en       = (pin_func_sel == `FTC_PIN_OVT);

	// Stored values follow the current format bit, no re-conversion
	assign temp_signed = cfg5_reg.twos_compl ? temp_raw
		: temp_raw - `FTC_TEMP_OFFSET;

	// GPIO; oe_n low while driving
	assign gpio_mode      = (pin_func_sel == `FTC_PIN_GPIO);
	assign gpio_oe_n      = ~(gpio_mode && cfg5_reg.gpio_direction);
	assign gpio_out       = cfg5_reg.gpio_polarity ? gpio_level
		: ~gpio_level;
	assign gpio_in_active = gpio_mode && !cfg5_reg.gpio_direction
		&& gpio_s2_reg;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	limit_write_a: assert property (
		req.wr && req.addr == `FTC_OFF_LIMIT
		|=> assert_time_limit_reg == $past(req.wdata))
		else $error("limit write lost");
	zero_limit_a: assert property (
		ovt_active && assert_time_limit_reg == 8'h00 |=> flag_reg)
		else $error("zero limit did not flag");
	over_limit_a: assert property (
		tstate_reg == FTC_TIMING && ovt_active
		&& steps_reg > assert_time_limit_reg |=> flag_reg)
		else $error("over limit did not flag");
	flag_sticky_a: assert property (
		flag_reg && !int_flag_clr |=> flag_reg)
		else $error("flag dropped without clear");
	lock_holds_a: assert property (
		cfg_lock && req.wr && req.addr == `FTC_OFF_CFG5
		|=> $stable(cfg5_reg))
		else $error("locked config changed");
	timer_zero_a: assert property (
		steps_reg < `FTC_MIN_STEPS |-> assert_time_count == 8'h00)
		else $error("timer nonzero too early");
	// Each new assertion must start timing from zero
	timer_restart_a: assert property (
		!ovt_active |=> assert_time_count == 8'h00)
		else $error("timer kept count after release");
	pulse_map_a: assert property (
		pulse_count_a
		== {1'b0, pulses_reg.pulse_count_sel_a} + 3'h1)
		else $error("pulse count map wrong");
	pulse_reset_a: assert property (
		$past(srst) |-> pulses_reg == `FTC_RST_PULSES)
		else $error("pulse reset value wrong");
	gpio_drive_a: assert property (
		!gpio_oe_n |-> gpio_mode && cfg5_reg.gpio_direction)
		else $error("gpio driven wrongly");
	band_out_a: assert property (
		req.wr && req.addr == `FTC_OFF_CFG5 && !cfg_lock
		|=> pwm_band_sel == $past(req.wdata[1]))
		else $error("band bit wrong");

	trip_c: cover property (tstate_reg == FTC_TIMING ##1
		tstate_reg == FTC_TRIPPED);
	lock_c: cover property (cfg_lock && req.wr
		&& req.addr == `FTC_OFF_CFG5);
	clear_c: cover property (flag_reg && int_flag_clr);

endmodule : ftc_regs

// file: verification/ftc_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module ftc_host_model
	import ftc_pkg::*;
(
	// Clock
	input  wire logic       core_clk,
	// Register access
	output ftc_req_s        req,
	input  wire logic [7:0] rdata
);
	// Idle at time zero, no strobe
	initial req = '0;

	// One-cycle strobe; idle fields flip so stale values never match
	task automatic access(input logic w, input logic [7:0] a, d);
		@(posedge core_clk);
		req <= '{wr: w, rd: ~w, addr: a, wdata: d};
		@(posedge core_clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : access

	// Write one byte
	task automatic wr_reg(input logic [7:0] a, d);
		access(1'b1, a, d);
	endtask : wr_reg

	// Read data is registered, settled just after the strobe's edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		access(1'b0, a, 8'h00);
		#1;
		d = rdata;
	endtask : rd_reg
endmodule : ftc_host_model

// file: verification/ftc_regs_tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Register bank bench
// ----------------------------------------
module ftc_regs_tb;
	logic                core_clk, srst, cfg_lock, int_flag_clr;
	logic                overtemp_signal_n, gpio_in, gpio_level;
	logic                twos_compl, pwm_band_sel, gpio_out, gpio_oe_n;
	logic                pulse_count_sel_d_or_overtemp_int_flag, overtemp_pin_en;
	logic                fourth_speed_input_en, gpio_in_active;
	logic [1:0]          pin_func_sel;
	logic [2:0]          pulse_count_a, pulse_count_b;
	logic [2:0]          pulse_count_c, pulse_count_d;
	logic [7:0]          rdata, assert_time_count, temp_raw, temp_signed;
	logic [7:0]          d;
	ftc_pkg::ftc_req_s    req;
	ftc_pkg::ftc_pulses_s pulse_sel;
	int                  mismatches, n_tests, n;

	// Short step count keeps the timer runs brief
	ftc_regs #(.STEP_CYC(4)) ftc_regs_inst (.core_clk, .srst, .req,
		.rdata, .cfg_lock, .pin_func_sel, .overtemp_signal_n,
		.int_flag_clr, .pulse_count_sel_d_or_overtemp_int_flag, .assert_time_count,
		.pulse_sel, .pulse_count_a, .pulse_count_b, .pulse_count_c,
		.pulse_count_d, .twos_compl, .pwm_band_sel,
		.fourth_speed_input_en, .overtemp_pin_en, .temp_raw,
		.temp_signed, .gpio_in, .gpio_level, .gpio_out, .gpio_oe_n,
		.gpio_in_active);
	ftc_host_model ftc_host_model_inst (.core_clk, .req, .rdata);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, exp, input string m);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, v);
		ftc_host_model_inst.wr_reg(a, v);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, exp, input string m);
		ftc_host_model_inst.rd_reg(a, d);
		check(d, exp, m);
	endtask : rd

	// Assert the pin and count cycles until the flag shows
	task automatic ovt(input logic [7:0] lim);
		wr(8'h7a, lim);
		@(posedge core_clk) overtemp_signal_n <= 1'b0;
		for (n = 1; n < 40; n++) begin
			@(posedge core_clk);
			#1;
			if (n == 4) check(assert_time_count, 0, "timer early");
			if (pulse_count_sel_d_or_overtemp_int_flag === 1'b1) break;
		end
	endtask : ovt

	// Flag must outlive the assertion until cleared
	task automatic clr;
		@(posedge core_clk) overtemp_signal_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1 check(pulse_count_sel_d_or_overtemp_int_flag, 1, "flag sticky");
		@(posedge core_clk) int_flag_clr <= 1'b1;
		@(posedge core_clk) int_flag_clr <= 1'b0;
		#1 check(pulse_count_sel_d_or_overtemp_int_flag, 0, "flag clear");
	endtask : clr

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Run needs well under a thousand cycles
	initial begin
		#(100 * 20000);
		mismatches++;
		report_and_stop;
	end

	// Main sequence
	initial begin
		{srst, cfg_lock, int_flag_clr, overtemp_signal_n} = 4'b1001;
		{gpio_in, gpio_level, pin_func_sel} = 4'b0100;
		temp_raw = 8'h50;
		mismatches = 0;
		n_tests = 0;
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		rd(8'h7a, 8'h00, "limit reset");
		rd(8'h7b, 8'h55, "pulses reset");
		rd(8'h7c, 8'h00, "cfg5 reset");
		check({pulse_count_d, pulse_count_c, pulse_count_b,
			pulse_count_a}, 12'h492, "count decode");
		$display("test reset done");
		// One code per fan, then limit and an unmapped place
		wr(8'h7b, 8'he4);
		rd(8'h7b, 8'he4, "pulses rw");
		check(pulse_sel, 8'he4, "pulse fields");
		check({pulse_count_d, pulse_count_c, pulse_count_b,
			pulse_count_a}, 12'h8d1, "count codes");
		wr(8'h7a, 8'hff);
		wr(8'h80, 8'h11);
		rd(8'h80, 8'h00, "unmapped");
		rd(8'h7a, 8'hff, "limit rw");
		$display("test fields done");
		// Configuration word bits and spare nibble
		wr(8'h7c, 8'hf3);
		rd(8'h7c, 8'hf3, "cfg5 rw");
		check({twos_compl, pwm_band_sel}, 2'b11, "fmt band");
		check(temp_signed, 8'h50, "twos temp");
		wr(8'h7c, 8'h0c);
		@(posedge core_clk) pin_func_sel <= 2'h3;
		#1 check({twos_compl, pwm_band_sel}, 0, "fmt band");
		check(temp_signed, 8'h10, "offset temp");
		check({gpio_oe_n, gpio_out}, 2'b01, "gpio hi");
		@(posedge core_clk) gpio_in <= 1'b1;
		wr(8'h7c, 8'h08);
		repeat (2) @(posedge core_clk);
		#1 check({gpio_oe_n, gpio_in_active}, 2'b11, "gpio in");
		wr(8'h7c, 8'h04);
		check(gpio_out, 0, "gpio lo");
		check(gpio_in_active, 0, "gpio out mode");
		@(posedge core_clk) pin_func_sel <= 2'h0;
		#1 check(gpio_oe_n, 1, "gpio off");
		@(posedge core_clk) cfg_lock <= 1'b1;
		wr(8'h7c, 8'haa);
		rd(8'h7c, 8'h04, "locked");
		@(posedge core_clk) cfg_lock <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			@(posedge core_clk) pin_func_sel <= c[1:0];
			#1 check({fourth_speed_input_en, overtemp_pin_en},
				{c == 0, c == 1}, "pin role");
		end
		$display("test config done");
		// Timer: zero limit, then a limit of three steps
		@(posedge core_clk) pin_func_sel <= 2'h1;
		ovt(8'h00);
		check(n <= 4, 1, "zero limit");
		clr;
		ovt(8'h03);
		check(n > 12 && n < 26, 1, "limit time");
		check(pulse_count_sel_d_or_overtemp_int_flag, 1, "flag set");
		check(assert_time_count, 8'h04, "timer steps");
		clr;
		$display("test timer done");
		report_and_stop;
	end
endmodule : ftc_regs_tb
